// *** level_edge.sv ***
// Rising and falling edge finder for a vector of same-clock levels
`timescale 1ns/10ps
module level_edge #(
	parameter int W = 1
) (
	input  logic         clock,
	input  logic         sys_rst,
	input  logic [W-1:0] lvl,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);

	typedef struct packed {
		logic [W-1:0] prev;
	} edge_s;

	edge_s q;
	edge_s d;

	always_comb begin
		d      = q;
		d.prev = lvl;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Level low at reset, so a bit held high through reset gives one rise
	assign rise = lvl & ~q.prev;
	assign fall = ~lvl & q.prev;

endmodule : level_edge

// *** task_ctrl_asserts.sv ***
// Concurrent checks on the task link between host and device ends
`timescale 1ns/10ps
module task_ctrl_asserts (
	input logic                                                              clock,
	input logic                                                              sys_rst,
	input logic [task_ctrl_pkg::NUM_TASKS-1:0]                               pause,
	input logic [task_ctrl_pkg::NUM_TASKS-1:0]                               cstart,
	input logic [task_ctrl_pkg::NUM_TASKS-1:0]                               fbe,
	input logic [task_ctrl_pkg::NUM_TASKS-1:0]                               mreset,
	input logic [task_ctrl_pkg::NUM_TASKS-1:0]                               psel,
	input logic [task_ctrl_pkg::NUM_TASKS-1:0]                               teach,
	input logic [task_ctrl_pkg::NUM_TASKS-1:0]                               tsrc,
	input logic [task_ctrl_pkg::NUM_TASKS-1:0]                               exec,
	input logic [task_ctrl_pkg::NUM_TASKS-1:0]                               mstrobe,
	input logic [task_ctrl_pkg::NUM_TASKS-1:0][task_ctrl_pkg::MCODE_W-1:0]   mcode,
	input logic [task_ctrl_pkg::NUM_TASKS-1:0]                               tdone,
	input logic [task_ctrl_pkg::NUM_TASKS-1:0]                               err
);
	import task_ctrl_pkg::*;

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	// ****************************************
	// One set of checks per task
	// ****************************************
	for (genvar t = 0; t < NUM_TASKS; t++) begin : g_task
		sequence s_sel_start;
			$rose(cstart[t]) && psel[t] && !exec[t] && !pause[t] && !fbe[t];
		endsequence
		sequence s_paused_start;
			$rose(cstart[t]) && pause[t] && !exec[t];
		endsequence
		sequence s_code_wait;
			mstrobe[t] && !mreset[t] && !fbe[t];
		endsequence
		chk_start_runs: assert property (s_sel_start |=> exec[t] && !err[t])
			else $error("select start did not run");
		chk_pause_blocks: assert property (s_paused_start |=> !exec[t])
			else $error("start taken while paused");
		chk_code_stands: assert property (s_code_wait |=> mstrobe[t])
			else $error("code strobe dropped without reset");
		chk_mrst_clears: assert property ($rose(mreset[t]) |=> !mstrobe[t] && mcode[t] == '0)
			else $error("code reset did not clear");
		chk_mrst_supp: assert property (mreset[t] && $past(mreset[t]) |-> !mstrobe[t])
			else $error("code output while reset held");
		chk_teach_done: assert property ($rose(teach[t]) |=> tdone[t])
			else $error("teach complete missing");
		chk_tdone_clear: assert property ($fell(teach[t]) |=> !tdone[t])
			else $error("teach complete stuck");
		chk_pause_hold: assert property (pause[t] && exec[t] |=> pause[t])
			else $error("pause released while executing");
		chk_mrst_hold: assert property (mreset[t] && mstrobe[t] |=> mreset[t])
			else $error("code reset released early");
		chk_tsrc_stable: assert property (teach[t] && !tdone[t] |=> $stable(tsrc[t]))
			else $error("teach source moved");
		chk_teach_hold: assert property (teach[t] && !tdone[t] |=> teach[t])
			else $error("teach released early");
	end
endmodule : task_ctrl_asserts

// *** task_ctrl_dev.sv ***
// Motion executor end: per-task pause, code handshake, program select, teach
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/10ps
module task_ctrl_dev (
	input  logic                                                     clock,
	input  logic                                                     sys_rst,
	task_link_if.dev                                                 lnk,
	input  logic [task_ctrl_pkg::NUM_TASKS-1:0]                      blk_end,
	input  logic [task_ctrl_pkg::NUM_TASKS-1:0]                      blk_mvalid,
	input  logic [task_ctrl_pkg::NUM_TASKS-1:0][task_ctrl_pkg::MCODE_W-1:0]
	                                                                 blk_mcode,
	input  logic [task_ctrl_pkg::NUM_TASKS-1:0]                      axes_moving,
	input  logic [task_ctrl_pkg::NUM_TASKS-1:0]                      prog_edited,
	input  logic [task_ctrl_pkg::NUM_TASKS-1:0][task_ctrl_pkg::AXES-1:0]
	             [task_ctrl_pkg::POS_W-1:0]                          cmd_pos,
	input  logic [task_ctrl_pkg::NUM_TASKS-1:0][task_ctrl_pkg::AXES-1:0]
	             [task_ctrl_pkg::POS_W-1:0]                          enc_pos,
	input  logic [task_ctrl_pkg::TASK_W-1:0]                         pos_rd_task,
	input  logic [task_ctrl_pkg::AXIS_W-1:0]                         pos_rd_axis,
	input  logic [task_ctrl_pkg::TADDR_W-1:0]                        pos_rd_addr,
	output logic [task_ctrl_pkg::POS_W-1:0]                          pos_rd_data,
	output logic [task_ctrl_pkg::NUM_TASKS-1:0]                      run_go,
	output logic [task_ctrl_pkg::NUM_TASKS-1:0]                      run_top,
	output logic [task_ctrl_pkg::NUM_TASKS-1:0][task_ctrl_pkg::PROG_W-1:0]
	                                                                 run_prog,
	output logic [task_ctrl_pkg::NUM_TASKS-1:0]                      blk_next,
	output logic [task_ctrl_pkg::NUM_TASKS-1:0]                      blk_kill,
	output logic [task_ctrl_pkg::NUM_TASKS-1:0]                      decel
);
	import task_ctrl_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		seq_e [NUM_TASKS-1:0]                           st;
		logic [NUM_TASKS-1:0][MCODE_W-1:0]              mcode;
		logic [NUM_TASKS-1:0]                           mstb;
		logic [NUM_TASKS-1:0]                           err;
		logic [NUM_TASKS-1:0]                           edit;
		logic [NUM_TASKS-1:0]                           tdone;
		logic [NUM_TASKS-1:0]                           decel;
		logic [NUM_TASKS-1:0]                           go;
		logic [NUM_TASKS-1:0]                           top;
		logic [NUM_TASKS-1:0]                           nxt;
		logic [NUM_TASKS-1:0]                           kill;
		logic [NUM_TASKS-1:0][PROG_W-1:0]               prog;
		logic [NUM_TASKS-1:0][AXES-1:0][TADDR_W-1:0]    taddr;
		logic [POS_W-1:0]                               rd_data;
	} dev_s;

	dev_s q;
	dev_s d;

	// Taught positions, one table per task and axis
	logic [POS_W-1:0] pos_mem [NUM_TASKS][AXES][TEACH_DEPTH];

	// ****************************************
	// Edge detection of host levels
	// ****************************************
	logic [NUM_TASKS*EV_N-1:0] lvl;
	logic [NUM_TASKS*EV_N-1:0] rise;
	logic [NUM_TASKS*EV_N-1:0] fall;

	always_comb begin
		lvl = '0;
		for (int t = 0; t < NUM_TASKS; t++) begin
			lvl[t*EV_N+EV_PAUSE]  = lnk.pause[t];
			lvl[t*EV_N+EV_CSTART] = lnk.cstart[t];
			lvl[t*EV_N+EV_FBE]    = lnk.fbe[t];
			lvl[t*EV_N+EV_MRST]   = lnk.mreset[t];
			lvl[t*EV_N+EV_TEACH]  = lnk.teach[t];
		end
	end

	level_edge #(
		.W (NUM_TASKS*EV_N)
	) u_edge (
		.clock   (clock),
		.sys_rst (sys_rst),
		.lvl     (lvl),
		.rise    (rise),
		.fall    (fall)
	);

	// ****************************************
	// Per-task sequencers
	// ****************************************
	always_comb begin
		d      = q;
		d.go   = '0;
		d.nxt  = '0;
		d.kill = '0;
		for (int t = 0; t < NUM_TASKS; t++) begin // [R20]
			// Any code, stalling or not, is dropped on reset rise
			if (rise[t*EV_N+EV_MRST]) begin
				d.mcode[t] = '0; // [R7] [R11]
				d.mstb[t]  = 1'h0;
			end
			unique case (q.st[t])
				SEQ_IDLE: begin
					// Start refused outright while pause or block end is held
					if (rise[t*EV_N+EV_CSTART] && !lnk.pause[t] && !lnk.fbe[t]) begin // [R3]
						if (lnk.psel[t]) begin
							d.prog[t] = lnk.prog_num[t]; // [R12]
							d.top[t]  = 1'h1;
							d.go[t]   = 1'h1;
							d.edit[t] = 1'h0;
							d.err[t]  = 1'h0;
							d.st[t]   = SEQ_RUN;
						end else if (q.edit[t]) begin
							d.err[t] = 1'h1; // [R13]
						end else begin
							d.top[t] = 1'h0; // [R2]
							d.go[t]  = 1'h1;
							d.st[t]  = SEQ_RUN;
						end
					end
				end
				SEQ_RUN: begin
					if (rise[t*EV_N+EV_FBE]) begin
						d.kill[t]  = 1'h1; // [R4]
						d.decel[t] = 1'h1;
						d.st[t]    = SEQ_STOP;
					end else if (rise[t*EV_N+EV_PAUSE]) begin
						d.decel[t] = 1'h1; // [R1]
						d.st[t]    = SEQ_STOP;
					end else if (blk_end[t]) begin
						// Reset already held means the code is never shown
						if (blk_mvalid[t] && mcode_valid(blk_mcode[t])
						    && !lnk.mreset[t]) begin // [R10]
							d.mcode[t] = blk_mcode[t];
							d.mstb[t]  = 1'h1;
						end
						if (blk_mvalid[t] && mcode_holds(blk_mcode[t])
						    && !lnk.mreset[t]) begin
							d.st[t] = SEQ_MWAIT; // [R6]
						end else if (lnk.cstart[t]) begin
							d.nxt[t] = 1'h1; // [R19] [R11]
						end else begin
							d.st[t] = SEQ_IDLE; // [R19]
						end
					end
				end
				SEQ_MWAIT: begin
					if (rise[t*EV_N+EV_FBE]) begin
						d.kill[t]  = 1'h1; // [R4]
						d.decel[t] = 1'h1;
						d.mcode[t] = '0;
						d.mstb[t]  = 1'h0;
						d.st[t]    = SEQ_STOP;
					end else if (rise[t*EV_N+EV_PAUSE]) begin
						d.decel[t] = 1'h1; // [R1]
						d.st[t]    = SEQ_STOP;
					end else if (fall[t*EV_N+EV_MRST]) begin
						if (lnk.cstart[t]) begin
							d.nxt[t] = 1'h1; // [R8]
							d.st[t]  = SEQ_RUN;
						end else begin
							d.st[t] = SEQ_IDLE; // [R19]
						end
					end
				end
				SEQ_STOP: begin
					// Flag stays up until motion has really ended
					if (!axes_moving[t]) begin
						d.decel[t] = 1'h0; // [R1]
						d.st[t]    = SEQ_IDLE;
					end
				end
			endcase
			// Edit notice placed after the clear so a coincident edit survives
			if (prog_edited[t]) begin
				d.edit[t] = 1'h1; // [R13]
			end
			// Teach ignores sequencer state and error
			if (rise[t*EV_N+EV_TEACH]) begin // [R16]
				for (int a = 0; a < AXES; a++) begin
					d.taddr[t][a] = q.taddr[t][a] + TADDR_W'(1); // [R14]
				end
				d.tdone[t] = 1'h1;
			end else if (!lnk.teach[t]) begin
				d.tdone[t] = 1'h0;
			end
		end
		d.rd_data = pos_mem[pos_rd_task][pos_rd_axis][pos_rd_addr];
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// Teach capture
	// ****************************************
	// Written at the old address, which the same edge then advances
	always_ff @(posedge clock) begin
		for (int t = 0; t < NUM_TASKS; t++) begin
			for (int a = 0; a < AXES; a++) begin
				if (rise[t*EV_N+EV_TEACH]) begin
					pos_mem[t][a][q.taddr[t][a]] <= lnk.tsrc[t] ? enc_pos[t][a]
					                                            : cmd_pos[t][a]; // [R17] [R14]
				end
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_comb begin
		for (int t = 0; t < NUM_TASKS; t++) begin
			lnk.exec[t] = q.st[t] != SEQ_IDLE;
		end
	end

	assign lnk.mstrobe = q.mstb;
	assign lnk.mcode   = q.mcode;
	assign lnk.tdone   = q.tdone;
	assign lnk.err     = q.err;
	assign pos_rd_data = q.rd_data;
	assign run_go      = q.go;
	assign run_top     = q.top;
	assign run_prog    = q.prog;
	assign blk_next    = q.nxt;
	assign blk_kill    = q.kill;
	assign decel       = q.decel;

endmodule : task_ctrl_dev

// *** task_ctrl_host.sv ***
// Host controller end: Avalon-MM register slave driving the task control bits
`timescale 1ns/10ps
module task_ctrl_host (
	input  logic                             clock,
	input  logic                             sys_rst,
	task_link_if.host                        lnk,
	input  logic [task_ctrl_pkg::ADDR_W-1:0] address,
	input  logic                             read,
	input  logic                             write,
	input  logic [31:0]                      writedata,
	input  logic [3:0]                       byteenable,
	output logic [31:0]                      readdata,
	output logic                             waitrequest
);
	import task_ctrl_pkg::*;

	typedef struct packed {
		logic [NUM_TASKS-1:0][15:0] ctrl;
		logic [NUM_TASKS-1:0]       pause;
		logic [NUM_TASKS-1:0]       cstart;
		logic [NUM_TASKS-1:0]       fbe;
		logic [NUM_TASKS-1:0]       mreset;
		logic [NUM_TASKS-1:0]       psel;
		logic [NUM_TASKS-1:0]       teach;
		logic [NUM_TASKS-1:0]       tsrc;
		logic [NUM_TASKS-1:0]       edit;
		logic                       ack;
		logic [31:0]                rdata;
	} host_s;

	host_s q;
	host_s d;

	logic                    req;
	logic                    in_ctrl;
	logic                    in_stat;
	logic [TASK_W-1:0]       idx;

	assign req     = read | write;
	assign in_ctrl = address[ADDR_W-1:4] == CTRL_BASE[ADDR_W-1:4];
	assign in_stat = address[ADDR_W-1:4] == STAT_BASE[ADDR_W-1:4];
	assign idx     = address[3:2];

	// ****************************************
	// Registers and control levels
	// ****************************************
	always_comb begin
		d     = q;
		d.ack = req & ~q.ack;
		if (req && !q.ack) begin
			d.rdata = 32'h0000_0000;
			if (in_ctrl) begin
				d.rdata[15:0] = q.ctrl[idx];
			end else if (in_stat) begin
				d.rdata[ST_EXEC]  = lnk.exec[idx];
				d.rdata[ST_MSTB]  = lnk.mstrobe[idx];
				d.rdata[ST_TDONE] = lnk.tdone[idx];
				d.rdata[ST_ERR]   = lnk.err[idx];
				d.rdata[ST_MCODE_LSB +: MCODE_W] = lnk.mcode[idx];
			end
		end
		if (write && q.ack && in_ctrl) begin
			if (byteenable[0]) begin
				d.ctrl[idx][7:0] = writedata[7:0];
			end
			if (byteenable[1]) begin
				d.ctrl[idx][15:8] = writedata[15:8];
			end
		end
		for (int t = 0; t < NUM_TASKS; t++) begin
			d.cstart[t] = q.ctrl[t][CTL_CSTART];
			d.fbe[t]    = q.ctrl[t][CTL_FBE];
			// Hardware holds past a software drop until the device answers
			d.pause[t]  = q.ctrl[t][CTL_PAUSE] | (q.pause[t] & lnk.exec[t]); // [R5]
			d.mreset[t] = q.ctrl[t][CTL_MRESET] | (q.mreset[t] & lnk.mstrobe[t]); // [R9]
			d.teach[t]  = q.ctrl[t][CTL_TEACH] | (q.teach[t] & ~lnk.tdone[t]); // [R15]
			d.tsrc[t]   = (q.teach[t] & ~lnk.tdone[t]) ? q.tsrc[t]
			                                           : q.ctrl[t][CTL_TSRC]; // [R18]
			d.psel[t]   = q.ctrl[t][CTL_PSEL] | q.edit[t]; // [R13]
			if (d.cstart[t] && !q.cstart[t] && q.psel[t]) begin
				d.edit[t] = 1'h0;
			end
			// Edit bit is a one-shot; a fresh edit beats the clear above
			if (q.ctrl[t][CTL_EDIT]) begin
				d.edit[t]           = 1'h1; // [R13]
				d.ctrl[t][CTL_EDIT] = 1'h0;
			end
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			q      <= '0;
			q.ctrl <= {NUM_TASKS{CTRL_RST}};
		end else begin
			q <= d;
		end
	end

	always_comb begin
		for (int t = 0; t < NUM_TASKS; t++) begin
			lnk.prog_num[t] = q.ctrl[t][CTL_PNUM_LSB +: PROG_W];
		end
	end

	assign lnk.pause  = q.pause;
	assign lnk.cstart = q.cstart;
	assign lnk.fbe    = q.fbe;
	assign lnk.mreset = q.mreset;
	assign lnk.psel   = q.psel;
	assign lnk.teach  = q.teach;
	assign lnk.tsrc   = q.tsrc;
	assign readdata    = q.rdata;
	assign waitrequest = req & ~q.ack;

endmodule : task_ctrl_host

// *** task_ctrl_pkg.sv ***
// Constants, types and helpers shared by both ends of the task control link
//
// Summary of operation
// R1 - Pause rise interrupts block, decelerates task axes
// R2 - Cycle start resumes paused program without select
// R3 - Cycle start ignored while pause bit held
// R4 - Forced block end beats simultaneous pause
// R5 - Host holds pause until executing flag drops
// R6 - Codes 0 to 499 stall block awaiting reset
// R7 - Reset rise clears code and strobe
// R8 - Execution resumes on reset bit fall
// R9 - Host holds reset until strobe drops
// R10 - Reset already on suppresses block's code
// R11 - Codes 500 to 999 cleared, never stall
// R12 - Select sampled at start; loads program number
// R13 - Edited program needs select, else error
// R14 - Teach rise stores position, bumps addresses
// R15 - Host holds teach until complete flag
// R16 - Teach accepted in any mode, even error
// R17 - Source bit picks encoder or commanded position
// R18 - Host keeps source bit stable until complete
// R19 - Cycle start checked at every block boundary
// R20 - Independent copy per task, four tasks
package task_ctrl_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int NUM_TASKS   = 4;
	localparam int TASK_W      = 2;
	localparam int AXES        = 2;
	localparam int AXIS_W      = 1;
	localparam int MCODE_W     = 10;
	localparam int PROG_W      = 8;
	localparam int POS_W       = 24;
	localparam int TADDR_W     = 6;
	localparam int TEACH_DEPTH = 2 ** TADDR_W;

	// ****************************************
	// Auxiliary code ranges
	// ****************************************
	localparam logic [MCODE_W-1:0] MCODE_HOLD_MAX = 10'h1F3;
	localparam logic [MCODE_W-1:0] MCODE_MAX      = 10'h3E7;

	// ****************************************
	// Per-task event vector layout
	// ****************************************
	localparam int EV_N      = 5;
	localparam int EV_PAUSE  = 0;
	localparam int EV_CSTART = 1;
	localparam int EV_FBE    = 2;
	localparam int EV_MRST   = 3;
	localparam int EV_TEACH  = 4;

	// ****************************************
	// Host register map
	// ****************************************
	localparam int                ADDR_W    = 6;
	localparam logic [ADDR_W-1:0] CTRL_BASE = 6'h00;
	localparam logic [ADDR_W-1:0] STAT_BASE = 6'h10;
	localparam logic [15:0]       CTRL_RST  = 16'h0000;
	localparam int CTL_PAUSE    = 0;
	localparam int CTL_CSTART   = 1;
	localparam int CTL_FBE      = 2;
	localparam int CTL_MRESET   = 3;
	localparam int CTL_PSEL     = 4;
	localparam int CTL_TEACH    = 5;
	localparam int CTL_TSRC     = 6;
	localparam int CTL_EDIT     = 7;
	localparam int CTL_PNUM_LSB = 8;
	localparam int ST_EXEC      = 0;
	localparam int ST_MSTB      = 1;
	localparam int ST_TDONE     = 2;
	localparam int ST_ERR       = 3;
	localparam int ST_MCODE_LSB = 16;

	typedef enum logic [1:0] {
		SEQ_IDLE  = 2'b00,
		SEQ_RUN   = 2'b01,
		SEQ_MWAIT = 2'b10,
		SEQ_STOP  = 2'b11
	} seq_e;

	function automatic logic mcode_valid(input logic [MCODE_W-1:0] code);
		return code <= MCODE_MAX;
	endfunction : mcode_valid

	function automatic logic mcode_holds(input logic [MCODE_W-1:0] code);
		return code <= MCODE_HOLD_MAX;
	endfunction : mcode_holds

endpackage : task_ctrl_pkg

// *** task_link_if.sv ***
// Control bits and status flags between host controller and motion executor
`timescale 1ns/10ps
interface task_link_if;
	import task_ctrl_pkg::*;

	// Host to device levels
	logic [NUM_TASKS-1:0]             pause;
	logic [NUM_TASKS-1:0]             cstart;
	logic [NUM_TASKS-1:0]             fbe;
	logic [NUM_TASKS-1:0]             mreset;
	logic [NUM_TASKS-1:0]             psel;
	logic [NUM_TASKS-1:0]             teach;
	logic [NUM_TASKS-1:0]             tsrc;
	logic [NUM_TASKS-1:0][PROG_W-1:0] prog_num;
	// Device to host flags
	logic [NUM_TASKS-1:0]              exec;
	logic [NUM_TASKS-1:0]              mstrobe;
	logic [NUM_TASKS-1:0][MCODE_W-1:0] mcode;
	logic [NUM_TASKS-1:0]              tdone;
	logic [NUM_TASKS-1:0]              err;

	modport dev (
		input  pause, cstart, fbe, mreset, psel, teach, tsrc, prog_num,
		output exec, mstrobe, mcode, tdone, err
	);

	modport host (
		output pause, cstart, fbe, mreset, psel, teach, tsrc, prog_num,
		input  exec, mstrobe, mcode, tdone, err
	);

endinterface : task_link_if

// *** task_pause_mcode_teach_ctrl_tb_top.sv ***
// Bench: register writes on the host end, flags and pulses seen on the device end
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_fail++; \
	$display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module task_pause_mcode_teach_ctrl_tb_top;
	import task_ctrl_pkg::*;

	localparam logic [31:0] M_PAUSE = 32'h0000_0001 << CTL_PAUSE;
	localparam logic [31:0] M_START = 32'h0000_0001 << CTL_CSTART;
	localparam logic [31:0] M_FBE   = 32'h0000_0001 << CTL_FBE;
	localparam logic [31:0] M_MRST  = 32'h0000_0001 << CTL_MRESET;
	localparam logic [31:0] M_PSEL  = 32'h0000_0001 << CTL_PSEL;
	localparam logic [31:0] M_TEACH = 32'h0000_0001 << CTL_TEACH;
	localparam logic [31:0] M_TSRC  = 32'h0000_0001 << CTL_TSRC;

	logic                                      clock, sys_rst, read, write, waitrequest;
	logic [ADDR_W-1:0]                         address;
	logic [31:0]                               writedata, readdata, st;
	logic [3:0]                                byteenable;
	logic [NUM_TASKS-1:0]                      blk_end, blk_mvalid, axes_moving, prog_edited;
	logic [NUM_TASKS-1:0][MCODE_W-1:0]         blk_mcode;
	logic [NUM_TASKS-1:0][AXES-1:0][POS_W-1:0] cmd_pos, enc_pos;
	logic [TASK_W-1:0]                         pos_rd_task;
	logic [AXIS_W-1:0]                         pos_rd_axis;
	logic [TADDR_W-1:0]                        pos_rd_addr;
	logic [POS_W-1:0]                          pos_rd_data;
	logic [NUM_TASKS-1:0]                      run_go, run_top, blk_next, blk_kill, decel;
	logic [NUM_TASKS-1:0]                      top_seen = '0;
	logic [NUM_TASKS-1:0][PROG_W-1:0]          run_prog, prog_seen;
	int                                        n_go[NUM_TASKS] = '{default: 0};
	int                                        n_next[NUM_TASKS] = '{default: 0};
	int                                        n_kill[NUM_TASKS] = '{default: 0};
	int                                        n_fail = 0, samples_checked = 0, cyc = 0;

	task_link_if task_link_if_i ();
	task_ctrl_host task_ctrl_host_i (.clock(clock), .sys_rst(sys_rst), .lnk(task_link_if_i),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest));
	task_ctrl_dev task_ctrl_dev_i (.clock(clock), .sys_rst(sys_rst), .lnk(task_link_if_i),
		.blk_end(blk_end), .blk_mvalid(blk_mvalid), .blk_mcode(blk_mcode),
		.axes_moving(axes_moving), .prog_edited(prog_edited), .cmd_pos(cmd_pos),
		.enc_pos(enc_pos), .pos_rd_task(pos_rd_task), .pos_rd_axis(pos_rd_axis),
		.pos_rd_addr(pos_rd_addr), .pos_rd_data(pos_rd_data), .run_go(run_go),
		.run_top(run_top), .run_prog(run_prog), .blk_next(blk_next),
		.blk_kill(blk_kill), .decel(decel));
	task_ctrl_asserts task_ctrl_asserts_i (.clock(clock), .sys_rst(sys_rst),
		.pause(task_link_if_i.pause), .cstart(task_link_if_i.cstart),
		.fbe(task_link_if_i.fbe), .mreset(task_link_if_i.mreset), .psel(task_link_if_i.psel),
		.teach(task_link_if_i.teach), .tsrc(task_link_if_i.tsrc), .exec(task_link_if_i.exec),
		.mstrobe(task_link_if_i.mstrobe), .mcode(task_link_if_i.mcode),
		.tdone(task_link_if_i.tdone), .err(task_link_if_i.err));

	always #50 clock = ~clock;

	// ****************************************
	// Pulse tallies, taken mid-cycle to stay clear of the edge
	// ****************************************
	always @(negedge clock) begin
		for (int i = 0; i < NUM_TASKS; i++) begin
			n_go[i] += int'(run_go[i] === 1'b1);
			n_next[i] += int'(blk_next[i] === 1'b1);
			n_kill[i] += int'(blk_kill[i] === 1'b1);
			if (run_go[i] === 1'b1) begin
				top_seen[i] = run_top[i];
				prog_seen[i] = run_prog[i];
			end
		end
	end

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict

	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clock);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		@(posedge clock);
		while (waitrequest !== 1'b0) @(posedge clock);
		st = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask : bus

	// Extra edges let the link flop and the device react
	task automatic ctl(input int t, input logic [31:0] v);
		bus(1'b1, CTRL_BASE + ADDR_W'(4 * t), v);
		repeat (3) @(posedge clock);
	endtask : ctl

	task automatic chk_st(input int t, input logic [3:0] f, input logic [MCODE_W-1:0] c);
		bus(1'b0, STAT_BASE + ADDR_W'(4 * t), 32'h0000_0000);
		`CHK("flags", f, st[3:0])
		`CHK("code", c, st[ST_MCODE_LSB +: MCODE_W])
	endtask : chk_st

	task automatic blk(input int t, input logic mv, input logic [MCODE_W-1:0] c);
		@(posedge clock);
		blk_end[t] <= 1'b1;
		blk_mvalid[t] <= mv;
		blk_mcode[t] <= c;
		@(posedge clock);
		blk_end[t] <= 1'b0;
		repeat (2) @(posedge clock);
	endtask : blk

	task automatic pos_chk(input logic [TADDR_W-1:0] a, input logic [POS_W-1:0] ex);
		@(posedge clock);
		pos_rd_addr <= a;
		repeat (2) @(posedge clock);
		@(negedge clock);
		`CHK("position", ex, pos_rd_data)
	endtask : pos_chk

	initial begin
		clock = 1'b0;
		sys_rst = 1'b1;
		{read, write, address, writedata, byteenable} = {2'b00, 6'h00, 32'h0000_0000, 4'hF};
		{blk_end, blk_mvalid, blk_mcode, axes_moving, prog_edited} = '0;
		{cmd_pos, enc_pos, pos_rd_axis, pos_rd_addr} = '0;
		pos_rd_task = 2'h3;
		cmd_pos[3][0] = 24'h11_1111;
		enc_pos[3][0] = 24'h22_2222;
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		// ****************************************
		// Code handshake on task 0
		// ****************************************
		ctl(0, M_START | M_PSEL | 32'h0000_2A00);
		`CHK("go", 1, n_go[0])
		`CHK("top", 1'b1, top_seen[0])
		`CHK("prog", 8'h2A, prog_seen[0])
		`CHK("others", 0, n_go[1] + n_go[2] + n_go[3])
		blk(0, 1'b0, 10'h000);
		`CHK("next", 1, n_next[0])
		blk(0, 1'b1, 10'h005);
		chk_st(0, 4'h3, 10'h005);
		ctl(0, M_START | M_MRST);
		chk_st(0, 4'h1, 10'h000);
		`CHK("next", 1, n_next[0])
		ctl(0, M_START);
		`CHK("next", 2, n_next[0])
		ctl(0, M_START | M_MRST);
		blk(0, 1'b1, 10'h007);
		chk_st(0, 4'h1, 10'h000);
		`CHK("next", 3, n_next[0])
		ctl(0, M_START);
		blk(0, 1'b1, 10'h258);
		chk_st(0, 4'h3, 10'h258);
		`CHK("next", 4, n_next[0])
		ctl(0, M_START | M_MRST);
		chk_st(0, 4'h1, 10'h000);
		ctl(0, 32'h0000_0000);
		blk(0, 1'b0, 10'h000);
		chk_st(0, 4'h0, 10'h000);
		// Pause, blocked start and resume on task 1
		axes_moving <= 4'h2;
		ctl(1, M_START | M_PSEL);
		ctl(1, M_START | M_PAUSE);
		@(negedge clock);
		`CHK("decel", 1'b1, decel[1])
		chk_st(1, 4'h1, 10'h000);
		// Software drops pause early; the link must keep it while executing
		ctl(1, M_START);
		`CHK("pause held", 1'b1, task_link_if_i.pause[1])
		bus(1'b0, CTRL_BASE + ADDR_W'(4), 32'h0000_0000);
		`CHK("ctrl", M_START, st)
		axes_moving <= 4'h0;
		repeat (3) @(posedge clock);
		`CHK("pause freed", 1'b0, task_link_if_i.pause[1])
		ctl(1, M_PAUSE);
		chk_st(1, 4'h0, 10'h000);
		ctl(1, M_PAUSE | M_START);
		`CHK("go", 1, n_go[1])
		ctl(1, 32'h0000_0000);
		ctl(1, M_START);
		`CHK("go", 2, n_go[1])
		`CHK("top", 1'b0, top_seen[1])
		// Forced end wins over a coincident pause on task 2
		ctl(2, M_START | M_PSEL);
		ctl(2, M_START | M_PAUSE | M_FBE);
		`CHK("kill", 1, n_kill[2])
		// Edit notice forces select on the next start without software help
		ctl(2, 32'h0000_0001 << CTL_EDIT);
		ctl(2, M_START);
		`CHK("edit forces top", 1'b1, top_seen[2])
		// Edit error, then teaching in error state on task 3
		@(posedge clock);
		prog_edited[3] <= 1'b1;
		@(posedge clock);
		prog_edited[3] <= 1'b0;
		ctl(3, M_START);
		chk_st(3, 4'h8, 10'h000);
		ctl(3, M_TEACH | M_TSRC);
		chk_st(3, 4'hC, 10'h000);
		ctl(3, 32'h0000_0000);
		ctl(3, M_TEACH);
		ctl(3, 32'h0000_0000);
		pos_chk(6'h00, 24'h22_2222);
		pos_chk(6'h01, 24'h11_1111);
		ctl(3, M_START | M_PSEL);
		chk_st(3, 4'h1, 10'h000);
		print_verdict();
	end
endmodule : task_pause_mcode_teach_ctrl_tb_top
